// ---- logic/ctl_sel_pkg.sv ----
// package: constants, enums and carriers for the control terminal selector
package ctl_sel_pkg;
    localparam int NUM_PLL      = 3;
    localparam int NUM_ENTRY    = 8;
    localparam int SEL_W        = 3;
    localparam int SPREAD_W     = 3;
    localparam int STATE_W      = 2;
    localparam int ROLE_BIT_POS = 6; // pin-role bit within byte 02
    localparam logic [7:0] ROLE_BYTE_IDX = 8'h02;
    localparam logic [2:0] SPREAD_OFF    = 3'h0;
    localparam logic [SEL_W-1:0] UPPER_FORCED_ZERO = 3'h0;

    // output stage states
    typedef enum logic [1:0] {
        OUT_POWER_DOWN = 2'h0,
        OUT_HIGH_Z     = 2'h1,
        OUT_DRIVE_LOW  = 2'h2,
        OUT_ACTIVE     = 2'h3
    } out_state_e;

    // spread amount in hundredths of a percent, per code
    typedef logic [7:0] spread_amt_t;

    // one entry of the control table, per pll fields plus single-output choice
    typedef struct packed {
        logic [NUM_PLL-1:0]          freq_choice_bit;
        logic [NUM_PLL-1:0][2:0]     spread_code;
        logic [NUM_PLL-1:0]          pair_output_choice;
        logic                        single_output_choice;
    } ctl_entry_s;

    // per-pll configuration register content
    typedef struct packed {
        logic       down_spread;
        logic [15:0] first_stored_freq;
        logic [15:0] second_stored_freq;
        out_state_e first_output_state;
        out_state_e second_output_state;
    } pll_cfg_s;

    // resolved per-pll operating point
    typedef struct packed {
        logic [15:0] freq;
        logic        down_spread;
        spread_amt_t spread_amt;
        out_state_e  pair_state;
    } pll_op_s;

    localparam logic [15:0] FREQ_PASS_DEFAULT = 16'h0000;

    // factory entries: entry 0 all high-z, entry 1 all active, spread off, first freq
    localparam ctl_entry_s FACTORY_ENTRY_OFF = '{
        freq_choice_bit: 3'h0, spread_code: 9'h000,
        pair_output_choice: 3'h0, single_output_choice: 1'b0};
    localparam ctl_entry_s FACTORY_ENTRY_ON = '{
        freq_choice_bit: 3'h0, spread_code: 9'h000,
        pair_output_choice: 3'h7, single_output_choice: 1'b1};
    localparam pll_cfg_s FACTORY_PLL_CFG = '{
        down_spread: 1'b0, first_stored_freq: FREQ_PASS_DEFAULT,
        second_stored_freq: FREQ_PASS_DEFAULT,
        first_output_state: OUT_HIGH_Z, second_output_state: OUT_ACTIVE};
    localparam out_state_e FACTORY_SINGLE_S0 = OUT_HIGH_Z;
    localparam out_state_e FACTORY_SINGLE_S1 = OUT_ACTIVE;
endpackage : ctl_sel_pkg

// ---- logic/control_terminal_selector.sv ----
// control terminal selector: picks a control entry from the selection pins
`timescale 1ns/1ps
// What this block does
// - three selection inputs choose stored control entries
// - all eight entries selectable in pin mode
// - 3-bit spread code decodes to spread amount
// - spread type, frequencies, states from pll config
// - frequency bit picks first or second frequency
// - pair choice picks pll output pair state
// - single-output choice picks generic state 0/1
// - shared pins serial by default; eeprom commit
// - pin mode ignores serial traffic on shared pins
// - grounded output rail forces serial pin role
// - lowest selection input is always selection only
// - reset loads factory configuration constants
// - serial role forces upper selection bits zero
// - factory entry 0 high-z, entry 1 active
// - top input msb, lowest input lsb
// - role byte takes effect only after eeprom commit
module control_terminal_selector
    import ctl_sel_pkg::*;
(
    // clock and reset
    input  wire logic                  mclk_in,
    input  wire logic                  rst_n_in,
    // selection pins
    input  wire logic                  select_in_low_in,
    input  wire logic                  select_in_mid_shared_data_in,
    input  wire logic                  select_in_high_shared_clock_in,
    // supply sense: high while the output rail is held at ground
    input  wire logic                  output_supply_rail_grounded_in,
    // serial register write port (decoded bytes)
    input  wire logic                  byte_write_in,
    input  wire logic [7:0]            byte_index_in,
    input  wire logic [7:0]            byte_data_in,
    input  wire logic                  eeprom_commit_in,
    // table and configuration writes from the serial register file
    input  wire logic                  entry_write_in,
    input  wire logic [SEL_W-1:0]      entry_index_in,
    input  wire ctl_entry_s            entry_data_in,
    input  wire logic                  pll_cfg_write_in,
    input  wire logic [1:0]            pll_cfg_index_in,
    input  wire pll_cfg_s              pll_cfg_data_in,
    input  wire logic                  single_cfg_write_in,
    input  wire out_state_e            single_first_output_state_in,
    input  wire out_state_e            single_second_output_state_in,
    // resolved outputs
    output logic [SEL_W-1:0]           active_entry_out,
    output pll_op_s [NUM_PLL-1:0]      pll_op_out,
    output out_state_e                 single_output_state_out,
    output logic                       serial_port_enabled_out
);

    ////////////////////////////////////////////////////////////////////////
    // spread code decode, used once per pll
    function automatic spread_amt_t spread_amount(input logic [2:0] code);
        spread_amt_t amt;
        amt = 8'h00;
        unique case (code)
            3'h0: amt = 8'h00;
            3'h1: amt = 8'h19;
            3'h2: amt = 8'h32;
            3'h3: amt = 8'h4b;
            3'h4: amt = 8'h64;
            3'h5: amt = 8'h7d;
            3'h6: amt = 8'h96;
            3'h7: amt = 8'hc8;
        endcase
        return amt;
    endfunction : spread_amount

    ////////////////////////////////////////////////////////////////////////
    // three-stage pin synchronisers; change counted once stages 2 and 3 agree
    logic [SEL_W-1:0] sync1_reg, sync2_reg, sync3_reg, pins_reg;
    logic [SEL_W-1:0] sync1_next, sync2_next, sync3_next, pins_next;
    logic             rail_s1_reg, rail_s2_reg, rail_s3_reg, rail_reg;
    logic             rail_s1_next, rail_s2_next, rail_s3_next, rail_next;

    always_comb
    begin
        sync1_next = {select_in_high_shared_clock_in, select_in_mid_shared_data_in,
                      select_in_low_in};
        sync2_next = sync1_reg;
        sync3_next = sync2_reg;
        pins_next  = pins_reg;
        for (int i = 0; i < SEL_W; i++)
        begin
            if (sync2_reg[i] == sync3_reg[i])
                pins_next[i] = sync3_reg[i];
        end
        rail_s1_next = output_supply_rail_grounded_in;
        rail_s2_next = rail_s1_reg;
        rail_s3_next = rail_s2_reg;
        rail_next    = (rail_s2_reg == rail_s3_reg) ? rail_s3_reg : rail_reg;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sync1_reg   <= '0;
            sync2_reg   <= '0;
            sync3_reg   <= '0;
            pins_reg    <= '0;
            rail_s1_reg <= 1'b0;
            rail_s2_reg <= 1'b0;
            rail_s3_reg <= 1'b0;
            rail_reg    <= 1'b0;
        end
        else
        begin
            sync1_reg   <= sync1_next;
            sync2_reg   <= sync2_next;
            sync3_reg   <= sync3_next;
            pins_reg    <= pins_next;
            rail_s1_reg <= rail_s1_next;
            rail_s2_reg <= rail_s2_next;
            rail_s3_reg <= rail_s3_next;
            rail_reg    <= rail_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin role: volatile bit vs committed copy; only the committed one counts
    logic role_vol_reg, role_ee_reg;
    logic role_vol_next, role_ee_next;
    logic serial_role;

    always_comb
    begin
        role_vol_next = role_vol_reg;
        role_ee_next  = role_ee_reg;
        if (byte_write_in && serial_role && byte_index_in == ROLE_BYTE_IDX)
            role_vol_next = byte_data_in[ROLE_BIT_POS];
        if (eeprom_commit_in && serial_role)
            role_ee_next = role_vol_reg;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            role_vol_reg <= 1'b0; // default serial
            role_ee_reg  <= 1'b0;
        end
        else
        begin
            role_vol_reg <= role_vol_next;
            role_ee_reg  <= role_ee_next;
        end
    end

    // grounded rail overrides committed pin mode
    assign serial_role = !role_ee_reg || rail_reg;

    ////////////////////////////////////////////////////////////////////////
    // entry table and configuration; reset restores the factory image
    ctl_entry_s            table_reg [NUM_ENTRY];
    ctl_entry_s            table_next [NUM_ENTRY];
    pll_cfg_s [NUM_PLL-1:0] pcfg_reg, pcfg_next;
    out_state_e            ss0_reg, ss1_reg, ss0_next, ss1_next;

    // writes only land while the shared pins carry the serial port
    always_comb
    begin
        table_next = table_reg;
        pcfg_next  = pcfg_reg;
        ss0_next   = ss0_reg;
        ss1_next   = ss1_reg;
        if (serial_role)
        begin
            if (entry_write_in)
                table_next[entry_index_in] = entry_data_in;
            if (pll_cfg_write_in && pll_cfg_index_in < 2'(NUM_PLL))
                pcfg_next[pll_cfg_index_in] = pll_cfg_data_in;
            if (single_cfg_write_in)
            begin
                ss0_next = single_first_output_state_in;
                ss1_next = single_second_output_state_in;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            for (int e = 0; e < NUM_ENTRY; e++)
                table_reg[e] <= (e == 1) ? FACTORY_ENTRY_ON : FACTORY_ENTRY_OFF;
            pcfg_reg <= {NUM_PLL{FACTORY_PLL_CFG}};
            ss0_reg  <= FACTORY_SINGLE_S0;
            ss1_reg  <= FACTORY_SINGLE_S1;
        end
        else
        begin
            table_reg <= table_next;
            pcfg_reg  <= pcfg_next;
            ss0_reg   <= ss0_next;
            ss1_reg   <= ss1_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // entry selection and resolution into operating points
    logic [SEL_W-1:0]       idx;
    ctl_entry_s             ent;
    logic [SEL_W-1:0]       act_next;
    pll_op_s [NUM_PLL-1:0]  op_next, op_reg;
    out_state_e             single_next, single_reg;
    logic                   act_en_reg;
    logic [SEL_W-1:0]       act_reg;

    always_comb
    begin
        // low pin is always a selection input; upper bits forced in serial role
        if (serial_role)
            idx = {UPPER_FORCED_ZERO[SEL_W-1:1], pins_reg[0]};
        else
            idx = pins_reg;
        ent      = table_reg[idx];
        act_next = idx;
        for (int p = 0; p < NUM_PLL; p++)
        begin
            op_next[p].freq = ent.freq_choice_bit[p] ? pcfg_reg[p].second_stored_freq
                                                     : pcfg_reg[p].first_stored_freq;
            op_next[p].down_spread = pcfg_reg[p].down_spread;
            op_next[p].spread_amt  = spread_amount(ent.spread_code[p]);
            op_next[p].pair_state  = ent.pair_output_choice[p]
                                   ? pcfg_reg[p].second_output_state
                                   : pcfg_reg[p].first_output_state;
        end
        single_next = ent.single_output_choice ? ss1_reg : ss0_reg;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            act_reg    <= '0;
            op_reg     <= '0;
            single_reg <= OUT_HIGH_Z;
            act_en_reg <= 1'b1;
        end
        else
        begin
            act_reg    <= act_next;
            op_reg     <= op_next;
            single_reg <= single_next;
            act_en_reg <= serial_role;
        end
    end

    assign active_entry_out        = act_reg;
    assign pll_op_out              = op_reg;
    assign single_output_state_out = single_reg;
    assign serial_port_enabled_out = act_en_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence commit_pin_mode;
        eeprom_commit_in && serial_role && role_vol_reg;
    endsequence

    upper_forced_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        serial_role |=> active_entry_out[SEL_W-1:1] == '0)
        else $error("upper selection bits not forced in serial role");
    low_passes_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        1'b1 |=> active_entry_out[0] == $past(pins_reg[0]))
        else $error("low selection input not used");
    full_index_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !serial_role |=> active_entry_out == $past(pins_reg))
        else $error("pin mode index wrong");
    commit_role_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        commit_pin_mode ##1 !rail_reg |=> !serial_port_enabled_out)
        else $error("committed pin mode not applied");
    rail_override_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        rail_reg |=> serial_port_enabled_out)
        else $error("grounded rail did not force serial role");
    no_write_pin_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !serial_role |=> $stable(role_vol_reg) && $stable(role_ee_reg))
        else $error("write accepted in pin mode");
    freq_pick_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !ent.freq_choice_bit[0] |=> pll_op_out[0].freq == $past(pcfg_reg[0].first_stored_freq))
        else $error("frequency choice wrong");
    spread_off_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ent.spread_code[0] == SPREAD_OFF |=> pll_op_out[0].spread_amt == 8'h00)
        else $error("spread off not decoded");
    // per bit: a settled bit may move while another bit is still unsettled
    sync_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        sync2_reg != sync3_reg
        |=> ((pins_reg ^ $past(pins_reg)) & $past(sync2_reg ^ sync3_reg)) == '0)
        else $error("unsettled pin accepted");
    pair_pick_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ent.pair_output_choice[1]
        |=> pll_op_out[1].pair_state == $past(pcfg_reg[1].second_output_state))
        else $error("pair output state choice wrong");
    single_pick_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !ent.single_output_choice |=> single_output_state_out == $past(ss0_reg))
        else $error("single output state choice wrong");
    role_byte_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        byte_write_in && serial_role && byte_index_in == ROLE_BYTE_IDX
        |=> role_vol_reg == $past(byte_data_in[ROLE_BIT_POS]))
        else $error("role byte write did not take effect");
endmodule : control_terminal_selector

// ---- sim/sel_pin_driver.sv ----
// partner model: controller that drives the selection pin levels
`timescale 1ns/1ps
module sel_pin_driver
(
    // clock and requested levels
    input  wire logic       mclk_in,
    input  wire logic [2:0] level_in,
    input  wire logic       traffic_in,
    // selection pins
    output logic            low_out,
    output logic            mid_out,
    output logic            high_out
);
    // static levels; shared pins toggle each cycle while serial traffic runs
    initial {low_out, mid_out, high_out} = 3'h0;
    always @(negedge mclk_in)
    begin
        low_out  <= level_in[0];
        mid_out  <= traffic_in ? ~mid_out : level_in[1];
        high_out <= traffic_in ? ~high_out : level_in[2];
    end
endmodule : sel_pin_driver

// ---- sim/tb_top.sv ----
// testbench for the control terminal selector
`timescale 1ns/1ps
module tb_top;
    import ctl_sel_pkg::*;
    logic                  mclk_in = 1'b0, rst_n_in = 1'b0, rail = 1'b0, traffic = 1'b0;
    logic [2:0]            lvl = 3'h0, eidx = 3'h0, act;
    logic                  s_lo, s_mid, s_hi, bw = 1'b0, cm = 1'b0, ew = 1'b0;
    logic                  pw = 1'b0, sw = 1'b0, sen, role;
    logic [7:0]            bidx = 8'h00, bdat = 8'h00;
    logic [1:0]            pidx = 2'h0;
    ctl_entry_s            edat = '0;
    pll_cfg_s              pdat = '0;
    out_state_e            st0 = OUT_POWER_DOWN, st1 = OUT_POWER_DOWN, sgl, es0, es1;
    pll_op_s [NUM_PLL-1:0] op;
    ctl_entry_s            tbl [NUM_ENTRY];
    pll_cfg_s              cfg [NUM_PLL];
    int                    err_count = 0, n_tests = 0;
    logic [15:0]           lf = 16'h004d;

    always #10 mclk_in = ~mclk_in;

    sel_pin_driver drv (.mclk_in(mclk_in), .level_in(lvl), .traffic_in(traffic),
        .low_out(s_lo), .mid_out(s_mid), .high_out(s_hi));

    control_terminal_selector dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .select_in_low_in(s_lo), .select_in_mid_shared_data_in(s_mid),
        .select_in_high_shared_clock_in(s_hi), .output_supply_rail_grounded_in(rail),
        .byte_write_in(bw), .byte_index_in(bidx), .byte_data_in(bdat),
        .eeprom_commit_in(cm), .entry_write_in(ew), .entry_index_in(eidx),
        .entry_data_in(edat), .pll_cfg_write_in(pw), .pll_cfg_index_in(pidx),
        .pll_cfg_data_in(pdat), .single_cfg_write_in(sw), .single_first_output_state_in(st0),
        .single_second_output_state_in(st1), .active_entry_out(act), .pll_op_out(op),
        .single_output_state_out(sgl), .serial_port_enabled_out(sen));

    ////////////////////////////////////////////////////////////////////////////////
    // random source, fixed start so every run repeats
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction : rnd

    // expected operating point of one pll for entry i
    function automatic pll_op_s exp_op(int p, logic [2:0] i);
        pll_op_s o;
        o.freq = tbl[i].freq_choice_bit[p] ? cfg[p].second_stored_freq
                                           : cfg[p].first_stored_freq;
        o.down_spread = cfg[p].down_spread;
        o.spread_amt = (tbl[i].spread_code[p] == 3'h7) ? 8'hc8
                     : 8'(tbl[i].spread_code[p]) * 8'h19;
        o.pair_state = tbl[i].pair_output_choice[p] ? cfg[p].second_output_state
                                                    : cfg[p].first_output_state;
        return o;
    endfunction : exp_op

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_val(string n, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected %s: expected %0h seen %0h", n, e, g);
        end
    endtask : chk_val

    task automatic chk_op(string n, pll_op_s e, pll_op_s g);
        n_tests++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected %s: expected %0h seen %0h", n, e, g);
        end
    endtask : chk_op

    // settle time covers the pin synchroniser plus output register
    task automatic check_all(string tag);
        logic       ser;
        logic [2:0] ei;
        ser = !role || rail;
        ei = ser ? {2'h0, lvl[0]} : lvl;
        repeat (8) @(negedge mclk_in);
        chk_val("serial_en", ser, sen);
        chk_val("entry", ei, act);
        for (int p = 0; p < NUM_PLL; p++)
            chk_op("pll_op", exp_op(p, ei), op[p]);
        chk_val("single", tbl[ei].single_output_choice ? es1 : es0, sgl);
        $display("test %s done, %0d unexpected so far", tag, err_count);
    endtask : check_all

    ////////////////////////////////////////////////////////////////////////////////
    // writes only land in the model while the shared pins are serial
    task automatic wr_entry(logic [2:0] i, ctl_entry_s d);
        @(negedge mclk_in);
        eidx = i;
        edat = d;
        ew = 1'b1;
        @(negedge mclk_in);
        ew = 1'b0;
        if (!role || rail) tbl[i] = d;
    endtask : wr_entry

    task automatic wr_cfg(logic [1:0] p, logic [47:0] r);
        @(negedge mclk_in);
        pidx = p;
        pdat = pll_cfg_s'(r[36:0]);
        pw = 1'b1;
        @(negedge mclk_in);
        pw = 1'b0;
        if ((!role || rail) && p < NUM_PLL) cfg[p] = pdat;
    endtask : wr_cfg

    task automatic wr_single(logic [3:0] r);
        @(negedge mclk_in);
        st0 = out_state_e'(r[1:0]);
        st1 = out_state_e'(r[3:2]);
        sw = 1'b1;
        @(negedge mclk_in);
        sw = 1'b0;
        if (!role || rail)
        begin
            es0 = st0;
            es1 = st1;
        end
    endtask : wr_single

    // role byte write, then commit one cycle later when c is set
    task automatic wr_role(logic v, logic c);
        @(negedge mclk_in);
        bidx = ROLE_BYTE_IDX;
        bdat = 8'(v) << ROLE_BIT_POS;
        bw = 1'b1;
        @(negedge mclk_in);
        bw = 1'b0;
        cm = c;
        @(negedge mclk_in);
        cm = 1'b0;
        if (c && (!role || rail)) role = v;
    endtask : wr_role

    task automatic do_reset(int n);
        rst_n_in = 1'b0;
        repeat (n) @(negedge mclk_in);
        rst_n_in = 1'b1;
        role = 1'b0;
        es0 = FACTORY_SINGLE_S0;
        es1 = FACTORY_SINGLE_S1;
        foreach (tbl[i]) tbl[i] = (i == 1) ? FACTORY_ENTRY_ON : FACTORY_ENTRY_OFF;
        foreach (cfg[i]) cfg[i] = FACTORY_PLL_CFG;
    endtask : do_reset

    task automatic finish_test();
        $display("counts: %0d compared, %0d unexpected", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        do_reset(12);
        lvl = 3'h6;
        check_all("factory_off");
        chk_val("off_state", OUT_HIGH_Z, op[2].pair_state);
        lvl = 3'h1;
        traffic = 1'b1;
        check_all("factory_on");
        chk_val("on_state", OUT_ACTIVE, sgl);
        for (int i = 0; i < NUM_ENTRY; i++) wr_entry(3'(i), ctl_entry_s'(rnd()));
        for (int p = 0; p < NUM_PLL; p++) wr_cfg(2'(p), {rnd(), rnd(), rnd()});
        wr_cfg(2'h3, {rnd(), rnd(), rnd()});
        wr_single(4'(rnd()));
        for (int c = 0; c < 8; c++)
        begin
            edat = ctl_entry_s'(rnd());
            edat.spread_code = {3{3'(c)}};
            wr_entry(3'h1, edat);
            check_all("spread");
        end
        wr_role(1'b1, 1'b0);
        check_all("no_commit");
        traffic = 1'b0;
        wr_role(1'b1, 1'b1);
        for (int i = 0; i < NUM_ENTRY; i++)
        begin
            lvl = 3'(i);
            check_all("pin_mode");
        end
        wr_entry(3'h3, ctl_entry_s'(rnd()));
        wr_single(4'(rnd()));
        lvl = 3'h3;
        check_all("refused");
        rail = 1'b1;
        traffic = 1'b1;
        lvl = 3'h7;
        check_all("rail_low");
        wr_entry(3'h1, ctl_entry_s'(rnd()));
        check_all("rail_write");
        rail = 1'b0;
        traffic = 1'b0;
        lvl = 3'h1;
        check_all("rail_back");
        do_reset(3);
        lvl = 3'h5;
        check_all("reset_again");
        finish_test();
    end

    // watchdog far beyond the expected run of about 260 cycles
    initial
    begin
        #400000;
        err_count++;
        finish_test();
    end
endmodule : tb_top
